/* File: hdl/flash_prog_pkg.sv */
// Purpose: Shared constants and types for the serial flash program/erase controller.
// Assumes: 22-bit program address space, APB register window of 32-bit words.
// Notes: Register offsets are byte addresses on the APB side.
package flash_prog_pkg;
   localparam int ADDR_W = 22;
   localparam int ROW_LSB = 6;
   localparam int NUM_REGION = 5;
   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TABLE_PTR = 8'h04;
   localparam logic [7:0] OFS_CONFIG = 8'h08;
   localparam logic [7:0] OFS_PROTECT = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   // Control field positions.
   localparam int CTRL_WR = 0;
   localparam int CTRL_FREE = 1;
   localparam int CTRL_WREN = 2;
   // Configuration field positions.
   localparam int CFG_BOOT_SIZE_LSB = 0;
   localparam int CFG_VARIANT_LSB = 2;
   localparam int PROT_WP_LSB = 5;
   // Reset values.
   localparam logic [1:0] BOOT_SIZE_RST = 2'h0;
   localparam logic [2:0] VARIANT_RST = 3'h4;
   localparam logic [4:0] PROT_RST = 5'h00;
   // Variant codes.
   localparam logic [2:0] VAR_4K = 3'h0;
   localparam logic [2:0] VAR_8K = 3'h1;
   localparam logic [2:0] VAR_16K = 3'h2;
   localparam logic [2:0] VAR_24K = 3'h3;
   localparam logic [2:0] VAR_32K = 3'h4;
   // Last implemented address per variant.
   localparam logic [ADDR_W-1:0] LIMIT_4K = 22'h000fff;
   localparam logic [ADDR_W-1:0] LIMIT_8K = 22'h001fff;
   localparam logic [ADDR_W-1:0] LIMIT_16K = 22'h003fff;
   localparam logic [ADDR_W-1:0] LIMIT_24K = 22'h005fff;
   localparam logic [ADDR_W-1:0] LIMIT_32K = 22'h007fff;
   // Boot region ends.
   localparam logic [ADDR_W-1:0] BOOT_END_BIG = 22'h0007ff;
   localparam logic [ADDR_W-1:0] BOOT_END_16K = 22'h0003ff;
   localparam logic [ADDR_W-1:0] BOOT_END_256W = 22'h0001ff;
   localparam logic [ADDR_W-1:0] BOOT_END_512W = 22'h0003ff;
   localparam logic [ADDR_W-1:0] BOOT_END_1024W = 22'h0007ff;
   localparam logic [1:0] BOOT_SIZE_256W = 2'h0;
   localparam logic [1:0] BOOT_SIZE_512W = 2'h1;
   // Block size as address shift.
   localparam int BLK_SHIFT_8K = 13;
   localparam int BLK_SHIFT_4K = 12;
   // The erase pulse starts on this serial clock rise of the no-op command.
   localparam logic [2:0] ERASE_CLK_EDGE = 3'h4;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_ERASE = 2'b10
   } erase_state_e;

   typedef struct packed {
      logic valid;
      logic boot;
      logic [2:0] prot_idx;
   } region_s;
endpackage

/* File: hdl/region_map.sv */
// Purpose: Maps a code address to its protection region for the selected variant.
// Assumes: Variant and boot size come from configuration registers.
// Notes: Region index 0 is the boot region, 1..4 are numbered blocks 0..3.
`timescale 1ns/100ps
`default_nettype none
module region_map import flash_prog_pkg::*; (
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [2:0] variant,
   input wire logic [1:0] boot_region_size,
   output region_s region
);
   logic [ADDR_W-1:0] limit;
   logic [ADDR_W-1:0] boot_end;
   logic [ADDR_W-1:0] blk;

   // Block 0 starts right after the boot region, so a bigger boot shrinks it.
   always_comb begin
      limit = LIMIT_32K;
      boot_end = BOOT_END_BIG;
      blk = addr >> BLK_SHIFT_8K;
      case (variant)
         VAR_4K, VAR_8K: begin
            limit = (variant == VAR_4K) ? LIMIT_4K : LIMIT_8K;
            blk = addr >> BLK_SHIFT_4K;
            case (boot_region_size)
               BOOT_SIZE_256W: boot_end = BOOT_END_256W;
               BOOT_SIZE_512W: boot_end = BOOT_END_512W;
               default: boot_end = BOOT_END_1024W;
            endcase
         end
         VAR_16K: begin
            limit = LIMIT_16K;
            boot_end = BOOT_END_16K;
         end
         VAR_24K: limit = LIMIT_24K;
         default: limit = LIMIT_32K;
      endcase
      region.valid = (addr <= limit);
      region.boot = (addr <= boot_end);
      region.prot_idx = region.boot ? 3'h0 : 3'(blk[1:0] + 2'h0) + 3'h1;
   end
endmodule
`default_nettype wire

/* File: hdl/serial_flash_program_erase_ctrl.sv */
// Purpose: Program/verify mode entry and externally timed row erase of code flash.
// Assumes: APB register access from the core side, serial pins from a programmer.
// Notes: The serial clock runs far slower than pclk and is sampled, not used as a clock.
// Summary of operation
// - 32K variants: code 000000h-007FFFh in four 8-Kbyte blocks.
// - 24K variants: code 000000h-005FFFh in three 8-Kbyte blocks.
// - Boot region 000000h-0007FFh is kept apart from block 0.
// - Every block and the boot region is its own protection boundary.
// - 16K variants: two 8-Kbyte blocks, boot region ends at 0003FFh.
// - Smallest variants: one or two 4-Kbyte blocks, variable boot region.
// - Small boot region is 256, 512 or 1024 words by a two-bit field.
// - A larger boot region shrinks block 0 by the same amount.
// - Clock and data low, then high voltage enters program/verify mode.
// - Entering program/verify mode releases all unused I/O pins.
// - A 64-byte row erase only runs on unprotected blocks.
// - Rows sit on fixed 64-byte boundaries from address zero.
// - Erase runs while the fourth clock of the no-op stays high.
// - Erase ends when the serial clock returns low.
// - The row holding the table pointer is erased, any byte within.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module serial_flash_program_erase_ctrl import flash_prog_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic prog_serial_clock,
   input wire logic prog_serial_data,
   input wire logic highvolt_enable_pin,
   output logic prog_mode,
   output logic io_release,
   output logic erase_active,
   output logic [ADDR_W-1:0] erase_row_addr
);
   logic [2:0] sync_q;
   logic hv_s, ser_clk_s, ser_dat_s;
   logic hv_d_r, ser_clk_d_r;
   logic ser_clk_rise, ser_clk_fall, hv_rise;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   logic wr_r, wr_nxt, free_r, free_nxt, wren_r, wren_nxt;
   logic [ADDR_W-1:0] table_pointer_r, table_pointer_nxt;
   logic [1:0] boot_region_size_r, boot_region_size_nxt;
   logic [2:0] variant_r, variant_nxt;
   logic [4:0] cp_r, cp_nxt, wp_r, wp_nxt;
   logic refused_r, refused_nxt;
   erase_state_e state_r, state_nxt;
   logic [2:0] clk_cnt_r, clk_cnt_nxt;
   logic mode_r, mode_nxt, io_release_r;
   logic erase_active_r, erase_active_nxt;
   logic [ADDR_W-1:0] erase_row_r, erase_row_nxt;
   logic acc_done, wr_acc, go, allowed, hw_clear;
   region_s region;

   // Decode of the register window, used only for the error answers.
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == OFS_CTRL) || (a == OFS_TABLE_PTR) || (a == OFS_CONFIG) ||
               (a == OFS_PROTECT) || (a == OFS_STATUS);
   endfunction

   // Pins come from the programmer's domain and are synchronised first.
   sync_two_ff #(
      .W(3)
   ) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({highvolt_enable_pin, prog_serial_clock, prog_serial_data}),
      .q(sync_q)
   );
   assign hv_s = sync_q[2];
   assign ser_clk_s = sync_q[1];
   assign ser_dat_s = sync_q[0];

   region_map u_map (
      .addr(table_pointer_r),
      .variant(variant_r),
      .boot_region_size(boot_region_size_r),
      .region(region)
   );

   // Edge detection on the synchronised levels.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hv_d_r <= 1'b0;
         ser_clk_d_r <= 1'b0;
      end else begin
         hv_d_r <= hv_s;
         ser_clk_d_r <= ser_clk_s;
      end
   end
   assign ser_clk_rise = ser_clk_s & ~ser_clk_d_r;
   assign ser_clk_fall = ~ser_clk_s & ser_clk_d_r;
   assign hv_rise = hv_s & ~hv_d_r;

   // APB: one wait state, then the transfer completes with pready high.
   assign acc_done = psel & penable & pready_r;
   assign wr_acc = acc_done & pwrite & ~pslverr_r;

   // A start needs the mode, the enables and an unprotected, implemented row.
   assign go = wr_r & (state_r == ST_IDLE);
   assign allowed = mode_r & free_r & wren_r & region.valid &
                    ~cp_r[region.prot_idx] & ~wp_r[region.prot_idx];

   // Bus answer and register next values.
   always_comb begin
      pready_nxt = psel & penable & ~pready_r;
      pslverr_nxt = psel & penable & ~pready_r & ~mapped(paddr);
      prdata_nxt = prdata_r;
      if (psel & ~penable & ~pwrite) begin
         case (paddr)
            OFS_CTRL: prdata_nxt = {29'h0, wren_r, free_r, wr_r};
            OFS_TABLE_PTR: prdata_nxt = {10'h0, table_pointer_r};
            OFS_CONFIG: prdata_nxt = {27'h0, variant_r, boot_region_size_r};
            OFS_PROTECT: prdata_nxt = {22'h0, wp_r, cp_r};
            OFS_STATUS: prdata_nxt = {28'h0, refused_r, erase_active_r, io_release_r, mode_r};
            default: prdata_nxt = 32'h0;
         endcase
      end
      free_nxt = free_r;
      wren_nxt = wren_r;
      table_pointer_nxt = table_pointer_r;
      boot_region_size_nxt = boot_region_size_r;
      variant_nxt = variant_r;
      cp_nxt = cp_r;
      wp_nxt = wp_r;
      if (wr_acc) begin
         case (paddr)
            OFS_CTRL: begin
               free_nxt = pwdata[CTRL_FREE];
               wren_nxt = pwdata[CTRL_WREN];
            end
            OFS_TABLE_PTR: table_pointer_nxt = pwdata[ADDR_W-1:0];
            OFS_CONFIG: begin
               boot_region_size_nxt = pwdata[CFG_BOOT_SIZE_LSB +: 2];
               variant_nxt = pwdata[CFG_VARIANT_LSB +: 3];
            end
            OFS_PROTECT: begin
               cp_nxt = pwdata[4:0];
               wp_nxt = pwdata[PROT_WP_LSB +: 5];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
         free_r <= 1'b0;
         wren_r <= 1'b0;
         table_pointer_r <= '0;
         boot_region_size_r <= BOOT_SIZE_RST;
         variant_r <= VARIANT_RST;
         cp_r <= PROT_RST;
         wp_r <= PROT_RST;
      end else begin
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
         free_r <= free_nxt;
         wren_r <= wren_nxt;
         table_pointer_r <= table_pointer_nxt;
         boot_region_size_r <= boot_region_size_nxt;
         variant_r <= variant_nxt;
         cp_r <= cp_nxt;
         wp_r <= wp_nxt;
      end
   end

   // Mode entry needs clock and data low when the high voltage arrives.
   always_comb begin
      mode_nxt = mode_r;
      if (!hv_s) begin
         mode_nxt = 1'b0;
      end else if (hv_rise && !ser_clk_s && !ser_dat_s) begin
         mode_nxt = 1'b1;
      end
   end

   // Released pins track the mode exactly.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= 1'b0;
         io_release_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         io_release_r <= mode_nxt;
      end
   end

   // Erase sequencer. The pulse length belongs entirely to the programmer's clock and high-voltage pin.
   always_comb begin
      state_nxt = state_r;
      clk_cnt_nxt = clk_cnt_r;
      erase_active_nxt = erase_active_r;
      erase_row_nxt = erase_row_r;
      refused_nxt = refused_r;
      hw_clear = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (go) begin
               if (allowed) begin
                  state_nxt = ST_WAIT;
                  clk_cnt_nxt = 3'h0;
                  erase_row_nxt = {table_pointer_r[ADDR_W-1:ROW_LSB], 6'h00};
               end else begin
                  refused_nxt = 1'b1;
                  hw_clear = 1'b1;
               end
            end
         end
         ST_WAIT: begin
            if (ser_clk_rise) begin
               clk_cnt_nxt = clk_cnt_r + 3'h1;
               if (clk_cnt_r + 3'h1 == ERASE_CLK_EDGE) begin
                  state_nxt = ST_ERASE;
                  erase_active_nxt = 1'b1;
               end
            end
         end
         ST_ERASE: begin
            if (ser_clk_fall) begin
               state_nxt = ST_IDLE;
               erase_active_nxt = 1'b0;
               hw_clear = 1'b1;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            erase_active_nxt = 1'b0;
         end
      endcase
      // Losing the high voltage aborts any sequence at once.
      if (!mode_nxt) begin
         state_nxt = ST_IDLE;
         erase_active_nxt = 1'b0;
         hw_clear = hw_clear | (state_r != ST_IDLE);
      end
      // A fresh software start clears the refusal; a new refusal wins.
      if (wr_acc && paddr == OFS_CTRL && pwdata[CTRL_WR] && !(go && !allowed)) begin
         refused_nxt = 1'b0;
      end
      // Software set wins over the hardware clear in the same cycle.
      wr_nxt = wr_r & ~hw_clear;
      if (wr_acc && paddr == OFS_CTRL && pwdata[CTRL_WR]) begin
         wr_nxt = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         clk_cnt_r <= 3'h0;
         erase_active_r <= 1'b0;
         erase_row_r <= '0;
         refused_r <= 1'b0;
         wr_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         clk_cnt_r <= clk_cnt_nxt;
         erase_active_r <= erase_active_nxt;
         erase_row_r <= erase_row_nxt;
         refused_r <= refused_nxt;
         wr_r <= wr_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign prog_mode = mode_r;
   assign io_release = io_release_r;
   assign erase_active = erase_active_r;
   assign erase_row_addr = erase_row_r;

   // Checks on the sequencer and the map.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_entry_cond: assert property ($rose(mode_r) |-> $past(hv_rise && !ser_clk_s && !ser_dat_s))
      else $error("mode entered without clock and data low");
   chk_erase_in_mode: assert property (erase_active_r |-> mode_r)
      else $error("erase outside program mode");
   chk_io_release: assert property ($rose(mode_r) |-> io_release_r)
      else $error("pins not released on mode entry");
   chk_mode_exit: assert property (!hv_s |=> !mode_r && !erase_active_r)
      else $error("mode held after high voltage dropped");
   chk_fourth_edge: assert property ($rose(erase_active_r) |-> clk_cnt_r == ERASE_CLK_EDGE)
      else $error("erase began on wrong clock edge");
   chk_erase_ends: assert property (erase_active_r && ser_clk_fall |=> !erase_active_r ##1 !erase_active_r)
      else $error("erase did not end on clock low");
   chk_row_aligned: assert property ($rose(state_r == ST_WAIT) |-> erase_row_r[ROW_LSB-1:0] == 6'h00 &&
      erase_row_r[ADDR_W-1:ROW_LSB] == $past(table_pointer_r[ADDR_W-1:ROW_LSB]))
      else $error("erase row not taken from pointer");
   // A software start landing in the same cycle wins over the clear, so it is left out here.
   chk_prot_refuse: assert property (go && !allowed && !wr_acc |=> refused_r && !wr_r && state_r == ST_IDLE)
      else $error("protected or invalid row not refused");
   chk_start_allowed: assert property ($rose(state_r == ST_WAIT) |-> $past(allowed && region.valid))
      else $error("erase started on disallowed row");
   chk_boot_small: assert property (variant_r == VAR_4K && boot_region_size_r == BOOT_SIZE_256W &&
      table_pointer_r[ADDR_W-1:9] == 13'h1 |-> !region.boot && region.prot_idx == 3'h1)
      else $error("small boot region mapped wrongly");
endmodule
`default_nettype wire

/* File: hdl/sync_two_ff.sv */
// Purpose: Two flip-flop synchroniser for levels from outside the clock domain.
// Assumes: Inputs change slowly compared with the clock.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none
module sync_two_ff #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   // A zero-width chain would leave the output undriven.
   if (W < 1) begin : g_bad_width
      $error("sync width must be at least 1");
   end

   // Plain two-stage chain.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;
endmodule
`default_nettype wire

/* File: tb/flash_programmer_model.sv */
// Purpose: Behavioural device programmer that drives the serial pins of the controller.
// Assumes: Serial clock period of 125 ns; the clock stands low outside commands.
// Notes: Only mode entry, mode exit and the no-op erase command are modelled.
`timescale 1ns/100ps
`default_nettype none
module flash_programmer_model (
   output logic prog_serial_clock,
   output logic prog_serial_data,
   output logic highvolt_enable_pin
);
   // All pins start low with the high voltage off.
   initial begin
      prog_serial_clock = 1'b0;
      prog_serial_data = 1'b0;
      highvolt_enable_pin = 1'b0;
   end

   // This programmer only erases rows and never programs memory or configuration, so the session
   // order and the low-supply data clear are kept by doing nothing out of turn.
   // Clock and data settle before the high voltage rises; a high clock is a deliberate misuse.
   task automatic enter(input logic clk_high);
      prog_serial_clock = clk_high;
      prog_serial_data = 1'b0;
      #500;
      highvolt_enable_pin = 1'b1;
      #500;
      prog_serial_clock = 1'b0;
      #500;
   endtask

   // Dropping the high voltage ends the session.
   task automatic leave();
      highvolt_enable_pin = 1'b0;
      #500;
   endtask

   // No-op command: three full clocks, then the fourth rise is held by the caller.
   task automatic nop_start();
      prog_serial_data = 1'b0;
      repeat (3) begin
         #62.5 prog_serial_clock = 1'b1;
         #62.5 prog_serial_clock = 1'b0;
      end
      #62.5 prog_serial_clock = 1'b1;
   endtask

   // The clock falls and stays low so the array can discharge.
   task automatic nop_end(input int discharge_ns);
      prog_serial_clock = 1'b0;
      #(discharge_ns);
   endtask
endmodule
`default_nettype wire

/* File: tb/serial_flash_program_erase_ctrl_tb.sv */
// Purpose: Self-checking bench for the serial flash program/erase controller.
// Assumes: APB master on pclk and a programmer model on the serial pins.
// Notes: Transfer answers and erase rows are matched against queued notes by monitors.
`timescale 1ns/100ps
`default_nettype none
module serial_flash_program_erase_ctrl_tb import flash_prog_pkg::*;;
   typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} exp_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic prog_serial_clock, prog_serial_data, highvolt_enable_pin;
   logic prog_mode, io_release, erase_active, active_prev;
   logic [ADDR_W-1:0] erase_row_addr;
   exp_s exp_q[$];
   logic [ADDR_W-1:0] row_q[$];
   exp_s e;
   int fail_count = 0;
   int checks = 0;
   int cycles = 0;

   serial_flash_program_erase_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .prog_serial_clock(prog_serial_clock), .prog_serial_data(prog_serial_data),
      .highvolt_enable_pin(highvolt_enable_pin), .prog_mode(prog_mode), .io_release(io_release),
      .erase_active(erase_active), .erase_row_addr(erase_row_addr));
   flash_programmer_model u_prog (.prog_serial_clock(prog_serial_clock), .prog_serial_data(prog_serial_data),
      .highvolt_enable_pin(highvolt_enable_pin));

   // The system clock runs at 100 MHz.
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks++;
      if (seen !== want) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic summarize();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // One APB transfer; the note is queued at setup and only the bench timeout cuts the wait short.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      exp_q.push_back({d, m, err});
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask

   // Sets the map and protection, starts a row erase and times it with the serial clock.
   task automatic run_case(input logic [2:0] v, input logic [1:0] bs, input logic [9:0] prot,
                           input logic [21:0] base, input logic ok);
      logic [21:0] tp;
      tp = base | 22'($urandom_range(63, 0));
      wr(OFS_CONFIG, {27'h0, v, bs});
      wr(OFS_PROTECT, {22'h0, prot});
      wr(OFS_TABLE_PTR, {10'h0, tp});
      if (ok) begin
         row_q.push_back({tp[21:6], 6'h00});
      end
      wr(OFS_CTRL, 32'h7);
      u_prog.nop_start();
      repeat (30) @(posedge pclk);
      check({31'h0, erase_active}, {31'h0, ok});
      u_prog.nop_end(300);
      check({31'h0, erase_active}, 32'h0);
      apb(1'b0, OFS_STATUS, {28'h0, ~ok, 3'h3}, 32'hf, 1'b0);
      apb(1'b0, OFS_CTRL, 32'h0, 32'h1, 1'b0);
   endtask

   // Each completed transfer is compared with the oldest queued note.
   always @(posedge pclk) begin
      if (presetn === 1'b1 && pready === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(32'h1, 32'h0);
         end else begin
            e = exp_q.pop_front();
            check(prdata & e.m, e.d & e.m);
            check({31'h0, pslverr}, {31'h0, e.e});
         end
      end
   end

   // Each erase pulse start must match a queued row base.
   always @(posedge pclk) begin
      active_prev <= erase_active;
      if (erase_active === 1'b1 && active_prev !== 1'b1) begin
         if (row_q.size() == 0) begin
            check(32'h1, 32'h0);
         end else begin
            check({10'h0, erase_row_addr}, {10'h0, row_q.pop_front()});
         end
      end
   end

   // A hang is cut short well beyond the expected run length.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         summarize();
      end
   end

   // Main sequence.
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      presetn = 1'b0;
      void'($urandom(48732));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, then refusal of unmapped places.
      apb(1'b0, OFS_CTRL, 32'h0, 32'hffffffff, 1'b0);
      apb(1'b0, OFS_TABLE_PTR, 32'h0, 32'hffffffff, 1'b0);
      apb(1'b0, OFS_CONFIG, {27'h0, VARIANT_RST, BOOT_SIZE_RST}, 32'hffffffff, 1'b0);
      apb(1'b0, OFS_PROTECT, 32'h0, 32'hffffffff, 1'b0);
      apb(1'b0, OFS_STATUS, 32'h0, 32'hffffffff, 1'b0);
      apb(1'b1, 8'h14, 32'h7, 32'h0, 1'b1);
      apb(1'b0, 8'h40, 32'h0, 32'hffffffff, 1'b1);
      // An erase start outside program/verify mode is refused.
      wr(OFS_CTRL, 32'h7);
      apb(1'b0, OFS_STATUS, 32'h8, 32'hf, 1'b0);
      // High voltage raised with the clock high must not enter the mode.
      u_prog.enter(1'b1);
      check({31'h0, prog_mode}, 32'h0);
      u_prog.leave();
      u_prog.enter(1'b0);
      check({30'h0, prog_mode, io_release}, 32'h3);
      apb(1'b0, OFS_STATUS, 32'h3, 32'h7, 1'b0);
      // A start with the write enable clear is refused even in the mode.
      wr(OFS_CTRL, 32'h3);
      apb(1'b0, OFS_STATUS, 32'hb, 32'hf, 1'b0);
      run_case(VAR_32K, BOOT_SIZE_256W, 10'h002, 22'h000400, 1'b1);
      run_case(VAR_32K, BOOT_SIZE_256W, 10'h002, 22'h000900, 1'b0);
      run_case(VAR_32K, BOOT_SIZE_256W, 10'h200, 22'h006100, 1'b0);
      run_case(VAR_32K, BOOT_SIZE_256W, 10'h200, 22'h004100, 1'b1);
      run_case(VAR_24K, BOOT_SIZE_256W, 10'h000, 22'h006000, 1'b0);
      run_case(VAR_24K, BOOT_SIZE_256W, 10'h000, 22'h005fc0, 1'b1);
      run_case(VAR_16K, BOOT_SIZE_256W, 10'h001, 22'h000400, 1'b1);
      run_case(VAR_16K, BOOT_SIZE_256W, 10'h000, 22'h004000, 1'b0);
      run_case(VAR_4K, BOOT_SIZE_256W, 10'h002, 22'h000300, 1'b0);
      run_case(VAR_4K, 2'h2, 10'h002, 22'h000300, 1'b1);
      run_case(VAR_4K, BOOT_SIZE_512W, 10'h001, 22'h000300, 1'b0);
      run_case(VAR_8K, BOOT_SIZE_256W, 10'h000, 22'h002000, 1'b0);
      run_case(VAR_8K, 2'h3, 10'h000, 22'h001fc0, 1'b1);
      // Dropping the high voltage mid-pulse aborts the erase and leaves the mode.
      wr(OFS_TABLE_PTR, 32'h80);
      row_q.push_back(22'h000080);
      wr(OFS_CTRL, 32'h7);
      u_prog.nop_start();
      repeat (30) @(posedge pclk);
      u_prog.leave();
      check({30'h0, prog_mode, erase_active}, 32'h0);
      u_prog.nop_end(300);
      check(32'(row_q.size()), 32'h0);
      summarize();
   end
endmodule
`default_nettype wire
